// ===== cal_lock_pkg.sv
// constants, types and timing for the calibration lock and counter block
package cal_lock_pkg;
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned CODE_CHARS       = 12;
    localparam int unsigned PANEL_CODE_CHARS = 8;
    localparam int unsigned PANEL_DIGITS     = 6;
    localparam int unsigned MSG_CHARS        = 40;
    localparam int unsigned PANEL_MSG_CHARS  = 12;
    localparam int unsigned CNT_W            = 15;
    localparam int unsigned NUM_SLOTS        = 32;
    localparam int unsigned SLOT_W           = 5;
    localparam int unsigned ZERO_TIME_S      = 300;
    localparam int unsigned SLOT_CYCLES_DEF  = ZERO_TIME_S * (CLK_HZ / NUM_SLOTS);
    localparam logic [CNT_W-1:0] CNT_MAX     = 15'h7fff;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 15'h0000;
    localparam logic [3:0] LEN_ZERO          = 4'h0;
    localparam logic [5:0] MSG_LEN_ZERO      = 6'h00;
    localparam logic [7:0] CHR_A             = 8'h41;
    localparam logic [7:0] CHR_Z             = 8'h5a;
    localparam logic [7:0] CHR_LA            = 8'h61;
    localparam logic [7:0] CHR_LZ            = 8'h7a;
    localparam logic [7:0] CHR_0             = 8'h30;
    localparam logic [7:0] CHR_9             = 8'h39;
    localparam logic [7:0] CHR_SP            = 8'h20;
    localparam logic [7:0] PFX0              = 8'h51;
    localparam logic [7:0] PFX1              = 8'h4b;
    localparam logic [7:0] SHIPPED_CHAR      = 8'h30;
    localparam logic [3:0] SHIPPED_LEN       = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ZERO   = 2'b01,
        ST_GAIN   = 2'b10
    } cal_state_t;
endpackage : cal_lock_pkg

// ===== cal_lock.sv
// calibration security lock, counter, message and zero-adjust sequencer
// Functional notes
// - start secured; refuse code changes and adjustments until unsecured (message writes accepted while secured)
// - security code held in persistent storage
// - remote code 1-12 chars, letter first
// - panel code: prefix plus six digits
// - jumper shorted: any valid code unsecures
// - when unsecured, new code replaces old
// - count plus one per stored value
// - counter wraps after 32767 to zero
// - counter readable only, never written
// - counter held in persistent storage
// - message written remotely, read both sides
// - message 40 chars, panel shows 12
// - message held in persistent storage
// - adjustment starts only when unsecured
// - any panel key except shift aborts
// - device clear or local key aborts remote
// - terminal selector change aborts calibration
// - zero steps all ranges, stores each
// - separate front and rear offset sets
// - zero rewrites every offset of the terminal set selected at start
// - zero sequence takes about five minutes
`timescale 1ns/1ps
`default_nettype none
module cal_lock
    import cal_lock_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 security_override_jumper,
    input  wire logic                 unsecure_req,
    input  wire logic                 unsecure_from_panel,
    input  wire logic [CODE_CHARS*8-1:0] unsecure_code,
    input  wire logic [3:0]           unsecure_len,
    input  wire logic                 secure_req,
    input  wire logic                 new_code_req,
    input  wire logic [CODE_CHARS*8-1:0] new_code,
    input  wire logic [3:0]           new_code_len,
    input  wire logic                 msg_write_req,
    input  wire logic [MSG_CHARS*8-1:0] msg_write_data,
    input  wire logic [5:0]           msg_write_len,
    input  wire logic                 zero_start_req,
    input  wire logic                 gain_start_req,
    input  wire logic                 gain_store,
    input  wire logic                 start_remote,
    input  wire logic                 offset_ready,
    input  wire logic                 panel_key,
    input  wire logic                 panel_key_is_shift,
    input  wire logic                 local_key,
    input  wire logic                 device_clear,
    input  wire logic                 rear_selected,
    output logic                      secured,
    output logic                      code_rejected,
    output logic                      start_refused,
    output logic                      cal_busy,
    output logic                      cal_aborted,
    output logic                      zero_done,
    output logic [CNT_W-1:0]          cal_count,
    output logic [MSG_CHARS*8-1:0]    remote_msg,
    output logic [5:0]                remote_msg_len,
    output logic [PANEL_MSG_CHARS*8-1:0] panel_msg,
    output logic                      offset_store,
    output logic                      offset_rear,
    output logic [SLOT_W-1:0]         offset_slot
);
    // persistent values: kept across reset (backed by non-volatile storage)
    logic [CODE_CHARS*8-1:0] stored_code;
    logic [3:0]              stored_len;
    logic                    nv_init = 1'b0;
    logic [MSG_CHARS*8-1:0]  msg_mem;
    logic [5:0]              msg_len;
    logic [CNT_W-1:0]        count_mem;

    cal_state_t              state;
    logic                    remote_run;
    logic                    run_rear;
    logic                    sel_prev;
    logic [31:0]             slot_timer;
    logic [SLOT_W-1:0]       slot;
    logic                    slot_written;

    // character classes per position
    logic [CODE_CHARS-1:0] is_letter;
    logic [CODE_CHARS-1:0] is_digit;
    logic [CODE_CHARS-1:0] in_len;
    logic [CODE_CHARS-1:0] new_is_letter;
    logic [CODE_CHARS-1:0] new_is_digit;
    logic [CODE_CHARS-1:0] new_in_len;
    logic [CODE_CHARS-1:0] stored_digit;
    logic [CODE_CHARS-1:0] code_eq;
    genvar gi;
    generate
        for (gi = 0; gi < CODE_CHARS; gi++) begin : g_chr
            wire [7:0] c  = unsecure_code[gi*8 +: 8];
            wire [7:0] nc = new_code[gi*8 +: 8];
            wire [7:0] sc = stored_code[gi*8 +: 8];
            wire c_upper  = (c >= CHR_A) && (c <= CHR_Z);
            wire c_lower  = (c >= CHR_LA) && (c <= CHR_LZ);
            wire nc_upper = (nc >= CHR_A) && (nc <= CHR_Z);
            wire nc_lower = (nc >= CHR_LA) && (nc <= CHR_LZ);
            assign is_letter[gi]     = c_upper || c_lower;
            assign is_digit[gi]      = (c >= CHR_0 && c <= CHR_9);
            assign in_len[gi]        = 4'(gi) < unsecure_len;
            assign new_is_letter[gi] = nc_upper || nc_lower;
            assign new_is_digit[gi]  = (nc >= CHR_0 && nc <= CHR_9);
            assign new_in_len[gi]    = 4'(gi) < new_code_len;
            assign stored_digit[gi]  = (sc >= CHR_0 && sc <= CHR_9);
            assign code_eq[gi]       = !in_len[gi] || (c == sc);
        end
    endgenerate

    // remote format: 1..12 alphanumerics, letter first
    // lengths above twelve are refused outright
    wire remote_len_ok = (unsecure_len != LEN_ZERO) && (unsecure_len <= 4'(CODE_CHARS));
    wire new_len_ok    = (new_code_len != LEN_ZERO) && (new_code_len <= 4'(CODE_CHARS));
    wire remote_chr_ok = &(~in_len | is_letter | is_digit);
    wire new_chr_ok    = &(~new_in_len | new_is_letter | new_is_digit);
    wire remote_fmt_ok = remote_len_ok && is_letter[0] && remote_chr_ok;
    wire new_fmt_ok    = new_len_ok && new_is_letter[0] && new_chr_ok;
    // panel format: exactly six digits
    wire panel_fmt_ok  = (unsecure_len == 4'(PANEL_DIGITS))
                       && (&(~in_len | is_digit));
    wire fmt_ok        = unsecure_from_panel ? panel_fmt_ok : remote_fmt_ok;

    // panel code matches only against a stored prefix-plus-digits code
    wire stored_panel_ok = (stored_len == 4'(PANEL_CODE_CHARS))
                         && stored_code[7:0] == PFX0 && stored_code[15:8] == PFX1
                         && (&stored_digit[PANEL_CODE_CHARS-1:2]);
    logic panel_match;
    always_comb begin
        panel_match = stored_panel_ok;
        for (int i = 0; i < PANEL_DIGITS; i++) begin
            if (unsecure_code[i*8 +: 8] != stored_code[(i+2)*8 +: 8]) begin
                panel_match = 1'b0;
            end
        end
    end
    wire remote_match = (unsecure_len == stored_len) && (&code_eq);
    wire code_match   = unsecure_from_panel ? panel_match : remote_match;
    wire accept_code  = unsecure_req && fmt_ok
                      && (security_override_jumper || code_match);
    wire reject_code  = unsecure_req && !accept_code;

    // abort sources
    wire sel_changed  = (rear_selected != sel_prev);
    wire key_abort    = panel_key && !panel_key_is_shift;
    wire remote_abort = remote_run && (device_clear || local_key);
    wire running      = (state != ST_IDLE);
    wire abort        = running && (key_abort || remote_abort || sel_changed);

    wire start_any    = (zero_start_req || gain_start_req) && !running;
    wire start_ok     = start_any && !secured;
    wire start_zero   = start_ok && zero_start_req;
    wire start_gain   = start_ok && !zero_start_req;
    wire slot_tick    = (state == ST_ZERO) && (slot_timer == SLOT_CYCLES - 1);
    wire last_slot    = (slot == SLOT_W'(NUM_SLOTS - 1));
    wire do_offset    = (state == ST_ZERO) && !abort && offset_ready && !slot_written;
    wire do_gain      = (state == ST_GAIN) && !abort && gain_store;
    wire zero_finish  = slot_tick && !abort && last_slot;

    // every stored value bumps the count; 32767 wraps to 0
    wire store_event  = do_offset || do_gain;
    wire [CNT_W-1:0] next_count = (count_mem == CNT_MAX) ? CNT_ZERO
                                : CNT_W'(count_mem + 1'b1);

    // adjustment state machine
    cal_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_zero) begin
                    next_state = ST_ZERO;
                end else if (start_gain) begin
                    next_state = ST_GAIN;
                end
            end
            ST_ZERO: begin
                if (abort || zero_finish) begin
                    next_state = ST_IDLE;
                end
            end
            ST_GAIN: begin
                if (abort || do_gain) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // power-up marker for the persistent values
    always_ff @(posedge ref_clk) begin
        nv_init <= 1'b1;
    end

    // persistent code: no reset term, shipped code loaded once
    always_ff @(posedge ref_clk) begin
        if (!nv_init) begin
            stored_code <= {CODE_CHARS{SHIPPED_CHAR}};
            stored_len  <= SHIPPED_LEN;
        end else if (new_code_req && !secured && new_fmt_ok) begin
            stored_code <= new_code;
            stored_len  <= new_code_len;
        end
    end

    // message survives reset; only the remote write port loads it
    wire [5:0] msg_len_clamped = (msg_write_len > 6'(MSG_CHARS)) ? 6'(MSG_CHARS)
                                                                 : msg_write_len;
    always_ff @(posedge ref_clk) begin
        if (!nv_init) begin
            msg_mem <= {MSG_CHARS{CHR_SP}};
            msg_len <= MSG_LEN_ZERO;
        end else if (msg_write_req) begin
            msg_mem <= msg_write_data;
            msg_len <= msg_len_clamped;
        end
    end

    // counter survives reset; only store events move it
    always_ff @(posedge ref_clk) begin
        if (!nv_init) begin
            count_mem <= CNT_ZERO;
        end else if (store_event) begin
            count_mem <= next_count;
        end
    end

    // lock flag: an accepted code wins over a same-cycle secure request
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            secured <= 1'b1;
        end else if (accept_code) begin
            secured <= 1'b0;
        end else if (secure_req) begin
            secured <= 1'b1;
        end
    end

    // answers to unsecure and start requests
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            code_rejected <= 1'b0;
            start_refused <= 1'b0;
        end else begin
            code_rejected <= reject_code;
            start_refused <= start_any && secured;
        end
    end

    // adjustment state and its status pulses
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state       <= ST_IDLE;
            sel_prev    <= 1'b0;
            cal_aborted <= 1'b0;
            zero_done   <= 1'b0;
        end else begin
            state       <= next_state;
            sel_prev    <= rear_selected;
            cal_aborted <= abort;
            zero_done   <= zero_finish;
        end
    end

    // origin and terminal set latched when an adjustment starts
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            remote_run <= 1'b0;
            run_rear   <= 1'b0;
        end else if (start_ok) begin
            remote_run <= start_remote;
            run_rear   <= rear_selected;
        end
    end

    // slot sequencer: one offset slot per SLOT_CYCLES while zeroing
    wire slot_hold = (state != ST_ZERO) || (next_state != ST_ZERO);
    always_ff @(posedge ref_clk) begin
        if (!reset_n || slot_hold) begin
            slot_timer   <= 32'h0000_0000;
            slot         <= {SLOT_W{1'b0}};
            slot_written <= 1'b0;
        end else if (slot_tick) begin
            slot_timer   <= 32'h0000_0000;
            slot         <= SLOT_W'(slot + 1'b1);
            slot_written <= 1'b0;
        end else begin
            slot_timer   <= slot_timer + 32'h0000_0001;
            slot_written <= slot_written | do_offset;
        end
    end

    // busy follows the state register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cal_busy <= 1'b0;
        end else begin
            cal_busy <= (next_state != ST_IDLE);
        end
    end

    // no input ever loads the counter; it only mirrors storage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cal_count <= CNT_ZERO;
        end else begin
            cal_count <= count_mem;
        end
    end

    // message copies for the remote reader and the panel display
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            remote_msg     <= {MSG_CHARS*8{1'b0}};
            remote_msg_len <= MSG_LEN_ZERO;
            panel_msg      <= {PANEL_MSG_CHARS*8{1'b0}};
        end else begin
            remote_msg     <= msg_mem;
            remote_msg_len <= msg_len;
            panel_msg      <= msg_mem[PANEL_MSG_CHARS*8-1:0];
        end
    end

    // offset store strobe toward the constant memory
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            offset_store <= 1'b0;
            offset_rear  <= 1'b0;
            offset_slot  <= {SLOT_W{1'b0}};
        end else begin
            offset_store <= do_offset;
            offset_rear  <= run_rear;
            offset_slot  <= slot;
        end
    end
endmodule : cal_lock
`default_nettype wire

// ===== cal_lock_properties.sv
// concurrent checks on the calibration lock ports
`timescale 1ns/1ps
`default_nettype none
module cal_lock_properties
    import cal_lock_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES = 8
) (
    input wire logic             ref_clk,
    input wire logic             reset_n,
    input wire logic             security_override_jumper,
    input wire logic             unsecure_req,
    input wire logic             zero_start_req,
    input wire logic             gain_start_req,
    input wire logic             panel_key,
    input wire logic             panel_key_is_shift,
    input wire logic             local_key,
    input wire logic             device_clear,
    input wire logic             rear_selected,
    input wire logic             secured,
    input wire logic             code_rejected,
    input wire logic             start_refused,
    input wire logic             cal_busy,
    input wire logic             cal_aborted,
    input wire logic             zero_done,
    input wire logic [CNT_W-1:0] cal_count,
    input wire logic             offset_store,
    input wire logic             offset_rear
);
    logic [2:0] up;
    // counter shows 0 right after reset, then jumps to the stored value
    always_ff @(posedge ref_clk) begin
        up <= reset_n ? {up[1:0], 1'b1} : 3'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_hold; secured && !unsecure_req |=> secured; endproperty
    a_hold: assert property (p_hold) else $error("lock opened without request");
    property p_reject;
        secured && unsecure_req && !security_override_jumper ##1 code_rejected |-> secured;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected code unlocked");
    property p_refuse;
        (zero_start_req || gain_start_req) && secured && !cal_busy |=> start_refused && !cal_busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start while locked");
    property p_start; zero_start_req && !secured && !cal_busy |=> cal_busy; endproperty
    a_start: assert property (p_start) else $error("zero did not start");
    property p_key; cal_busy && panel_key && !panel_key_is_shift |=> cal_aborted && !cal_busy;
    endproperty
    a_key: assert property (p_key) else $error("key did not abort");
    property p_shift;
        cal_busy && panel_key && panel_key_is_shift && !local_key && !device_clear
            && $stable(rear_selected) |=> !cal_aborted;
    endproperty
    a_shift: assert property (p_shift) else $error("shift aborted");
    property p_sel; cal_busy && $changed(rear_selected) |=> cal_aborted; endproperty
    a_sel: assert property (p_sel) else $error("selector change did not abort");
    property p_rear;
        offset_store && $stable(rear_selected) |-> offset_rear == rear_selected;
    endproperty
    a_rear: assert property (p_rear) else $error("offset stored to wrong set");
    property p_step;
        up[2] && $changed(cal_count) |-> (cal_count - $past(cal_count)) == 15'h0001;
    endproperty
    a_step: assert property (p_step) else $error("counter moved by other than one");
    property p_done; zero_done |-> ##[0:1] !cal_busy; endproperty
    a_done: assert property (p_done) else $error("busy after zero done");
    c_done: cover property (zero_done);
    c_abort: cover property (cal_aborted);
    c_open: cover property (secured ##1 !secured);
    c_wrap: cover property ($past(cal_count) == CNT_MAX && cal_count == CNT_ZERO);
endmodule : cal_lock_properties
bind cal_lock cal_lock_properties #(.SLOT_CYCLES(SLOT_CYCLES)) u_props (.ref_clk, .reset_n,
    .security_override_jumper, .unsecure_req, .zero_start_req, .gain_start_req, .panel_key,
    .panel_key_is_shift, .local_key, .device_clear, .rear_selected, .secured, .code_rejected,
    .start_refused, .cal_busy, .cal_aborted, .zero_done, .cal_count, .offset_store,
    .offset_rear);
`default_nettype wire

// ===== cal_operator.sv
// operator model: reports one measured offset per slot while busy
`timescale 1ns/1ps
`default_nettype none
module cal_operator #(
    parameter int unsigned SLOT_CYCLES = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       cal_busy,
    input  wire logic [3:0] ready_dly,
    output logic            offset_ready
);
    int unsigned tick;
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !cal_busy) begin
            tick <= 0;
            offset_ready <= 1'b0;
        end else begin
            tick <= (tick == SLOT_CYCLES - 1) ? 0 : tick + 1;
            offset_ready <= (tick == ready_dly);
        end
    end
endmodule : cal_operator
`default_nettype wire

// ===== calibration_lock_and_counter_bench.sv
// self-checking bench for the calibration lock block
`timescale 1ns/1ps
`default_nettype none
module calibration_lock_and_counter_bench
    import cal_lock_pkg::*;
;
    localparam logic [9:0] P_UNS = 10'h200, P_SEC = 10'h100, P_NEW = 10'h080, P_MSG = 10'h040;
    localparam logic [9:0] P_ZERO = 10'h020, P_GAIN = 10'h010, P_GST = 10'h008;
    localparam logic [9:0] P_KEY = 10'h004, P_LOC = 10'h002, P_CLR = 10'h001;
    logic           ref_clk, reset_n, security_override_jumper, unsecure_from_panel;
    logic           panel_key_is_shift, start_remote, rear_selected, rs;
    logic [9:0]     pulses;
    logic [3:0]     unsecure_len, new_code_len, dly;
    logic [5:0]     msg_write_len, remote_msg_len;
    logic [95:0]    unsecure_code, new_code, panel_msg, pc;
    logic [319:0]   msg_write_data, remote_msg, m;
    logic [CNT_W-1:0] cal_count;
    logic [SLOT_W-1:0] offset_slot;
    logic           secured, code_rejected, start_refused, cal_busy, cal_aborted, zero_done;
    logic           offset_store, offset_rear, offset_ready;
    wire            unsecure_req, secure_req, new_code_req, msg_write_req, zero_start_req;
    wire            gain_start_req, gain_store, panel_key, local_key, device_clear;
    int             num_errors, checks_done, seed, nst, exp_cnt, i, r, k;
    assign {unsecure_req, secure_req, new_code_req, msg_write_req, zero_start_req,
            gain_start_req, gain_store, panel_key, local_key, device_clear} = pulses;
    cal_lock #(.SLOT_CYCLES(8)) i_dut (.ref_clk, .reset_n, .security_override_jumper,
        .unsecure_req, .unsecure_from_panel, .unsecure_code, .unsecure_len, .secure_req,
        .new_code_req, .new_code, .new_code_len, .msg_write_req, .msg_write_data,
        .msg_write_len, .zero_start_req, .gain_start_req, .gain_store, .start_remote,
        .offset_ready, .panel_key, .panel_key_is_shift, .local_key, .device_clear,
        .rear_selected, .secured, .code_rejected, .start_refused, .cal_busy, .cal_aborted,
        .zero_done, .cal_count, .remote_msg, .remote_msg_len, .panel_msg, .offset_store,
        .offset_rear, .offset_slot);
    cal_operator #(.SLOT_CYCLES(8)) i_op (.ref_clk, .reset_n, .cal_busy, .ready_dly(dly),
        .offset_ready);
    task automatic chk(input logic [319:0] got, input logic [319:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic pl(input logic [9:0] p);
        @(posedge ref_clk) pulses <= p;
        @(posedge ref_clk) pulses <= 10'h000;
        #1;
    endtask : pl
    task automatic uns(input logic [95:0] c, input logic [3:0] n, input logic p, input logic j);
        @(posedge ref_clk) unsecure_code <= c;
        unsecure_len <= n;
        unsecure_from_panel <= p;
        security_override_jumper <= j;
        pl(P_UNS);
    endtask : uns
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    always @(posedge ref_clk) begin
        if (offset_store === 1'b1) begin
            chk(offset_slot, nst);
            chk(offset_rear, rs);
            nst++;
            exp_cnt++;
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #3600000;
        num_errors++;
        finish_test;
    end
    initial begin
        {reset_n, security_override_jumper, unsecure_from_panel, pulses} = '0;
        {panel_key_is_shift, start_remote, rear_selected, rs, unsecure_len} = '0;
        {new_code_len, msg_write_len, unsecure_code, new_code, msg_write_data} = '0;
        {dly, nst, exp_cnt, num_errors, checks_done} = '0;
        seed = 5955;
        pc = '0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk(secured, 1'b1);
        chk(cal_count, CNT_ZERO);
        pl(P_ZERO);
        chk(start_refused, 1'b1);
        chk(cal_busy, 1'b0);
        uns(96'h444142, 4'h3, 1'b0, 1'b0);
        chk(code_rejected, 1'b1);
        chk(secured, 1'b1);
        m = {PFX1, PFX0};
        for (i = 2; i < 8; i++) m[8*i+:8] = CHR_0 + 8'($unsigned($random(seed)) % 10);
        pc = {48'h0, m[63:16]};
        @(posedge ref_clk) new_code <= m[95:0];
        new_code_len <= 4'h8;
        pl(P_NEW);
        uns(pc, 4'h6, 1'b1, 1'b0);
        chk(code_rejected, 1'b1);
        uns(96'h424131, 4'h3, 1'b0, 1'b1);
        chk(code_rejected, 1'b1);
        uns(96'h41, 4'hd, 1'b0, 1'b1);
        chk(code_rejected, 1'b1);
        uns(96'h41, 4'h1, 1'b0, 1'b1);
        chk(secured, 1'b0);
        pl(P_NEW);
        pl(P_SEC);
        chk(secured, 1'b1);
        uns(pc ^ (96'h1 << 40), 4'h6, 1'b1, 1'b0);
        chk(code_rejected, 1'b1);
        uns(pc, 4'h6, 1'b1, 1'b0);
        chk(secured, 1'b0);
        $display("test lock finished");
        for (i = 0; i < 40; i++) m[8*i+:8] = $random(seed);
        @(posedge ref_clk) msg_write_data <= m;
        msg_write_len <= 6'h28;
        pl(P_MSG);
        @(posedge ref_clk) #1 chk(remote_msg, m);
        chk(remote_msg_len, 6'h28);
        chk(panel_msg, m[95:0]);
        $display("test message finished");
        for (r = 0; r < 6; r++) begin
            @(posedge ref_clk) rs = (r == 1);
            rear_selected <= rs;
            dly <= r[0] ? 4'h6 : 4'h1;
            panel_key_is_shift <= r > 1;
            start_remote <= r > 3;
            nst = 0;
            pl(P_ZERO);
            chk(cal_busy, 1'b1);
            if (r > 1) begin
                pl(P_KEY);
                chk(cal_aborted, 1'b0);
                @(posedge ref_clk) panel_key_is_shift <= 1'b0;
                if (r == 3) begin
                    @(posedge ref_clk) rear_selected <= ~rs;
                    @(posedge ref_clk) #1;
                end else pl(r == 2 ? P_KEY : (r == 4 ? P_CLR : P_LOC));
                chk(cal_aborted, 1'b1);
                chk(cal_busy, 1'b0);
            end else begin
                for (k = 0; k < 2000; k++) begin
                    @(posedge ref_clk) #1;
                    if (zero_done === 1'b1) break;
                end
                chk(zero_done, 1'b1);
                @(posedge ref_clk) #1;
                chk(nst, NUM_SLOTS);
            end
            repeat (3) @(posedge ref_clk);
            #1 chk(cal_count, exp_cnt[14:0]);
        end
        $display("test zero finished");
        while (exp_cnt[14:0] !== CNT_MAX) begin
            @(posedge ref_clk) pulses <= P_GAIN;
            @(posedge ref_clk) pulses <= P_GST;
            exp_cnt++;
        end
        @(posedge ref_clk) pulses <= 10'h000;
        repeat (3) @(posedge ref_clk);
        #1 chk(cal_count, CNT_MAX);
        pl(P_GAIN);
        pl(P_GST);
        repeat (3) @(posedge ref_clk);
        #1 chk(cal_count, CNT_ZERO);
        $display("test counter finished");
        finish_test;
    end
endmodule : calibration_lock_and_counter_bench
`default_nettype wire
